// [hw/fpu_round_exception_pkg.sv]
// Shared constants and carriers of the floating-point rounding and exception unit.
// Assumes one core clock domain; the issuing pipeline and the AHB-Lite master share it.
package fpu_round_exception_pkg;

    // ------------------------------------------------------------------
    // Register map (word index = haddr[3:2])
    // ------------------------------------------------------------------
    localparam logic [1:0] REG_CTRL_IDX = 2'h0;
    localparam logic [1:0] REG_STATE_IDX = 2'h1;
    localparam logic [31:0] CTRL_RESET = 32'h00040001;
    localparam logic [31:0] CTRL_WMASK = 32'h003fffff;

    // ------------------------------------------------------------------
    // Field positions of fp_status_control
    // ------------------------------------------------------------------
    localparam int BANK_BIT = 21;
    localparam int SIZE_BIT = 20;
    localparam int PREC_BIT = 19;
    localparam int FLUSH_BIT = 18;
    localparam int CAUSE_LSB = 12;
    localparam int ENABLE_LSB = 7;
    localparam int FLAG_LSB = 2;
    localparam int RSEL_LSB = 0;
    // Source order inside the five-bit enable and flag fields.
    localparam int SRC_V = 4;
    localparam int SRC_Z = 3;
    localparam int SRC_O = 2;
    localparam int SRC_U = 1;
    localparam int SRC_I = 0;
    localparam logic [1:0] NEAREST_ROUNDING = 2'h0;
    localparam logic [1:0] TOWARD_ZERO_ROUNDING = 2'h1;

    // ------------------------------------------------------------------
    // Number formats
    // ------------------------------------------------------------------
    localparam logic [12:0] EXP_ONES_SP = 13'h00ff;
    localparam logic [12:0] EXP_ONES_DP = 13'h07ff;
    localparam logic [63:0] QNAN_SP = 64'h000000007fc00000;
    localparam logic [63:0] QNAN_DP = 64'h7ff8000000000000;
    localparam logic [2:0] LOAD_CYCLES_DEFAULT = 3'h4;

    typedef enum logic [3:0] {
        no_op = 4'h0,
        float_add_op = 4'h1,
        float_sub_op = 4'h2,
        float_mul_op = 4'h3,
        float_div_op = 4'h4,
        fused_mul_add_op = 4'h5,
        inner_product_op = 4'h6,
        matrix_vector_op = 4'h7,
        bank_toggle_op = 4'h8,
        size_toggle_op = 4'h9,
        float_move_op = 4'ha,
        control_load_op = 4'hb
    } fpu_op_t;

    // One instruction handed over by the core with its unrounded result.
    typedef struct packed {
        logic valid;
        fpu_op_t op;
        logic delay_slot;
        logic nan_input;
        logic zero_divisor;
        logic denorm_input;
        logic may_overflow;
        logic may_underflow;
        logic may_inexact;
        logic sign;
        logic [11:0] exp;
        logic [52:0] sig;
        logic round_bit;
        logic sticky;
        logic [63:0] move_data;
    } issue_t;

    // Committed outcome of one instruction.
    typedef struct packed {
        logic valid;
        logic write_en;
        logic pair;
        logic flush;
        logic [63:0] data;
    } result_t;

endpackage : fpu_round_exception_pkg

// [hw/fpu_round_exception_unit.sv]
// Rounding, exception and control-register logic of the floating-point unit.
// Assumes the core presents one instruction per valid cycle, holds off while busy is high,
// and hands over an unrounded significand already aligned to the selected precision.
//
// How it works
// - round_select 00 picks nearest rounding, 01 picks toward-zero rounding.
// - Nearest rounding breaks ties toward an even least significant bit.
// - Nearest rounding at or beyond the top boundary gives signed infinity.
// - Toward-zero truncates below the round bit and clamps to the largest magnitude.
// - With fpu_disable set, any instruction raises illegal or slot illegal.
// - Inexact fires on overflow, underflow or any rounding loss.
// - FPU error fires on denormal input when denorm_flush is 0, always trapping.
// - Each arithmetic operation rewrites all cause bits; flags are only ever set.
// - Invalid trap when enabled and matrix-vector or a real invalid operation.
// - Division-by-zero trap when enabled and a divide sees a zero divisor.
// - Overflow, underflow, inexact trap when enabled and the instruction could cause it.
// - All unit traps leave on one shared exception pulse.
// - A taken trap leaves the destination register unwritten.
// - Untrapped invalid gives quiet NaN; untrapped divide by zero gives signed infinity.
// - Untrapped overflow gives largest normal or infinity, by rounding mode.
// - Untrapped underflow gives signed denormal or zero, or zero when flushing.
// - Inner-product and matrix-vector results are approximate within a bound.
// - Inner-product and matrix-vector always set inexact cause and flag.
// - Matrix-vector always traps when the invalid enable is set.
// - Bank toggle flips bank_select in one cycle; a control load takes LOAD_CYCLES, four by default.
// - With pair_transfer_size set, moves carry an even/odd pair as two words.
// - Size toggle flips pair_transfer_size.
// - Arithmetic clears the whole cause field before recording new sources.
// - The status/control register resets to 0x00040001.
// - With denorm_flush set, denormal operands count as zero.
`timescale 1ns/1ns

module fpu_round_exception_unit
    import fpu_round_exception_pkg::*;
#(
    parameter logic [2:0] LOAD_CYCLES = LOAD_CYCLES_DEFAULT
) (
    input wire logic hclk, // Core clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // AHB-Lite slave select.
    input wire logic [31:0] haddr, // AHB-Lite address.
    input wire logic [1:0] htrans, // AHB-Lite transfer type.
    input wire logic hwrite, // AHB-Lite write strobe.
    input wire logic [2:0] hsize, // AHB-Lite size, word only.
    input wire logic [31:0] hwdata, // AHB-Lite write data.
    input wire logic hready, // AHB-Lite bus ready.
    output logic [31:0] hrdata, // AHB-Lite read data.
    output logic hreadyout, // AHB-Lite slave ready.
    output logic hresp, // AHB-Lite response, always OKAY.
    input wire issue_t issue, // Instruction from the core.
    input wire logic fpu_disable, // Status bit that forbids unit instructions.
    output result_t result, // Committed result.
    output logic fpu_exception, // Shared unit trap pulse.
    output logic illegal_instr, // General illegal instruction pulse.
    output logic slot_illegal_instr, // Slot illegal instruction pulse.
    output logic busy, // Control load in progress.
    output logic bank_select, // Current register bank.
    output logic pair_transfer_size // Current move width.
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The control load must settle in four to five cycles.
    if (LOAD_CYCLES < 3'h4 || LOAD_CYCLES > 3'h5) begin : g_bad_load
        $error("LOAD_CYCLES must be 4 or 5");
    end

    typedef struct packed {
        logic [31:0] ctrl;
        result_t res;
        logic exc;
        logic ill;
        logic slot_ill;
        logic [2:0] load_cnt;
        logic [31:0] load_val;
        logic wr_pend;
        logic [1:0] wr_idx;
        logic [31:0] rdata;
        logic ready;
        logic busy;
    } state_t;

    state_t s;
    state_t next_s;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Word decode for both the read path and the write path.
    function automatic logic reg_hit(input logic [1:0] idx, input logic [1:0] want);
        reg_hit = (idx == want);
    endfunction : reg_hit

    // Packs sign, exponent and fraction into the selected format.
    function automatic logic [63:0] pack(input logic dbl, input logic sgn, input logic [12:0] e,
                                         input logic [52:0] frac);
        if (dbl) begin
            pack = {sgn, e[10:0], frac[51:0]};
        end else begin
            pack = {32'h0, sgn, e[7:0], frac[22:0]};
        end
    endfunction : pack

    // ------------------------------------------------------------------
    // Datapath variables
    // ------------------------------------------------------------------
    logic [31:0] fp;
    logic dbl;
    logic flush_mode;
    logic nearest;
    logic inc;
    logic [53:0] sum;
    logic carry;
    logic hid;
    logic [12:0] e;
    logic [12:0] ones;
    logic [52:0] frac;
    logic loss;
    logic ovf;
    logic tiny;
    logic gfx;
    logic src_e, src_v, src_z, src_o, src_u, src_i;
    logic trap;
    logic [4:0] en;
    logic [63:0] val;

    // ------------------------------------------------------------------
    // Rounding datapath
    // ------------------------------------------------------------------
    // Rounding works on the current register so a trap and its cause land together.
    always_comb begin
        dbl = s.ctrl[PREC_BIT];
        flush_mode = s.ctrl[FLUSH_BIT];
        nearest = (s.ctrl[RSEL_LSB +: 2] == NEAREST_ROUNDING);
        // Toward-zero never increments, so the bits below the round bit simply drop.
        inc = nearest && issue.round_bit && (issue.sticky || issue.sig[0]);
        sum = {1'b0, issue.sig} + {53'h0, inc};
        carry = dbl ? sum[53] : sum[24];
        hid = dbl ? sum[52] : sum[23];
        // A denormal that rounds into the hidden bit becomes the smallest normal.
        e = {1'b0, issue.exp} + {12'h0, carry} + {12'h0, (issue.exp == 12'h0) && hid};
        // A carry only comes from an all-ones significand, so the fraction wraps to zero.
        frac = carry ? 53'h0 : sum[52:0];
        ones = dbl ? EXP_ONES_DP : EXP_ONES_SP;
        loss = issue.round_bit || issue.sticky;
        ovf = (e >= ones);
        tiny = (e == 13'h0) && (loss || (frac != 53'h0));
    end

    // ------------------------------------------------------------------
    // Exception sources and trap decision
    // ------------------------------------------------------------------
    always_comb begin
        en = s.ctrl[ENABLE_LSB +: 5];
        gfx = (issue.op == inner_product_op) || (issue.op == matrix_vector_op);
        // A flushed denormal operand is zero, so it raises no error.
        src_e = issue.denorm_input && !flush_mode;
        src_v = issue.nan_input;
        src_z = issue.zero_divisor && (issue.op == float_div_op);
        src_o = !src_v && !src_z && ovf;
        src_u = !src_v && !src_z && !ovf && (flush_mode ? tiny : tiny && loss);
        // The dot-product hardware drops small partial products, so it is never exact.
        src_i = (!src_v && !src_z && (loss || src_o || src_u)) || gfx;
        trap = src_e
            || (en[SRC_V] && (src_v || (issue.op == matrix_vector_op)))
            || (en[SRC_Z] && src_z)
            || (en[SRC_O] && issue.may_overflow)
            || (en[SRC_U] && issue.may_underflow)
            || (en[SRC_I] && (issue.may_inexact || gfx));
        // Default results when no trap is taken.
        if (src_v) begin
            val = dbl ? QNAN_DP : QNAN_SP;
        end else if (src_z) begin
            val = pack(dbl, issue.sign, ones, 53'h0);
        end else if (src_o && nearest) begin
            val = pack(dbl, issue.sign, ones, 53'h0);
        end else if (src_o) begin
            val = pack(dbl, issue.sign, ones - 13'h1, {53{1'b1}});
        end else if (tiny && flush_mode) begin
            val = pack(dbl, issue.sign, 13'h0, 53'h0);
        end else begin
            val = pack(dbl, issue.sign, e, frac);
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.res = '0;
        next_s.exc = 1'b0;
        next_s.ill = 1'b0;
        next_s.slot_ill = 1'b0;
        next_s.ready = 1'b1;
        next_s.wr_pend = 1'b0;
        fp = s.ctrl;
        // Bus write lands in its data phase; an instruction in the same cycle wins on flags.
        if (s.wr_pend && reg_hit(s.wr_idx, REG_CTRL_IDX)) begin
            fp = hwdata & CTRL_WMASK;
        end
        // Address phase: capture writes, and stage read data for the data phase.
        if (hsel && hready && htrans[1]) begin
            next_s.wr_pend = hwrite;
            next_s.wr_idx = haddr[3:2];
            if (hwrite) begin
                next_s.rdata = 32'h0;
            end else if (reg_hit(haddr[3:2], REG_CTRL_IDX)) begin
                next_s.rdata = s.ctrl;
            end else if (reg_hit(haddr[3:2], REG_STATE_IDX)) begin
                next_s.rdata = {29'h0, s.load_cnt};
            end else begin
                next_s.rdata = 32'h0;
            end
        end
        if (s.load_cnt != 3'h0) begin
            // The core holds off while a control load settles the unit state.
            next_s.load_cnt = s.load_cnt - 3'h1;
            if (s.load_cnt == 3'h1) begin
                fp = s.load_val & CTRL_WMASK;
            end
        end else if (issue.valid && issue.op != no_op) begin
            if (fpu_disable) begin
                next_s.ill = !issue.delay_slot;
                next_s.slot_ill = issue.delay_slot;
            end else begin
                case (issue.op)
                    bank_toggle_op: begin
                        fp[BANK_BIT] = !fp[BANK_BIT];
                    end
                    size_toggle_op: begin
                        fp[SIZE_BIT] = !fp[SIZE_BIT];
                    end
                    control_load_op: begin
                        next_s.load_cnt = LOAD_CYCLES;
                        next_s.load_val = issue.move_data[31:0];
                    end
                    float_move_op: begin
                        next_s.res.valid = 1'b1;
                        next_s.res.write_en = 1'b1;
                        next_s.res.pair = s.ctrl[SIZE_BIT];
                        next_s.res.data = s.ctrl[SIZE_BIT] ? issue.move_data
                                                            : {32'h0, issue.move_data[31:0]};
                    end
                    default: begin
                        // Cause is rebuilt whole; flags only accumulate.
                        fp[CAUSE_LSB +: 6] = {src_e, src_v, src_z, src_o, src_u, src_i};
                        fp[FLAG_LSB +: 5] = fp[FLAG_LSB +: 5] | {src_v, src_z, src_o, src_u, src_i};
                        next_s.res.valid = 1'b1;
                        next_s.res.write_en = !trap;
                        next_s.res.flush = issue.denorm_input && flush_mode;
                        next_s.res.data = trap ? 64'h0 : val;
                        next_s.exc = trap;
                    end
                endcase
            end
        end
        next_s.ctrl = fp;
        next_s.busy = (next_s.load_cnt != 3'h0);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.ctrl <= CTRL_RESET;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register except hresp, which is tied to OKAY
    // ------------------------------------------------------------------
    assign hrdata = s.rdata;
    assign hreadyout = s.ready;
    assign hresp = 1'b0;
    assign result = s.res;
    assign fpu_exception = s.exc;
    assign illegal_instr = s.ill;
    assign slot_illegal_instr = s.slot_ill;
    assign busy = s.busy;
    assign bank_select = s.ctrl[BANK_BIT];
    assign pair_transfer_size = s.ctrl[SIZE_BIT];

endmodule : fpu_round_exception_unit

// [tb/core_issue_model.sv]
// Model of the core that hands instructions to the unit, one at a time.
// Assumes the unit shares the core clock; only busy holds the core off.
`timescale 1ns/1ns
module core_issue_model
    import fpu_round_exception_pkg::*;
(
    input wire logic hclk, // Core clock.
    input wire logic busy, // Hold-off from the unit.
    output issue_t issue, // Instruction to the unit.
    output logic fpu_disable // Unit disable status bit.
);
    // Idle until the first instruction.
    initial begin
        issue = '0;
        fpu_disable = 1'b0;
    end

    // One instruction stands one cycle; nowait offers it during a load on purpose.
    // Busy is looked at mid-cycle so the hold-off is settled, never racing the edge.
    task automatic send(input issue_t ins, input logic dis, input logic nowait);
        @(negedge hclk);
        while (busy && !nowait) begin
            @(negedge hclk);
        end
        @(posedge hclk);
        issue <= ins;
        fpu_disable <= dis;
        @(posedge hclk);
        issue <= {1'b0, ~ins[$bits(issue_t)-2:0]}; // Stale fields are scrambled, not kept.
    endtask : send
endmodule : core_issue_model

// [tb/fpu_round_exception_chk.sv]
// Checker of the unit's instruction-side port behaviour.
// Assumes one clock domain and the default control load length of four cycles.
`timescale 1ns/1ns
module fpu_round_exception_chk
    import fpu_round_exception_pkg::*;
(
    input wire logic hclk, // Core clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire issue_t issue, // Instruction from the core.
    input wire logic fpu_disable, // Unit disable status bit.
    input wire result_t result, // Committed result.
    input wire logic fpu_exception, // Shared trap pulse.
    input wire logic illegal_instr, // Illegal instruction pulse.
    input wire logic slot_illegal_instr, // Slot illegal instruction pulse.
    input wire logic busy, // Control load in progress.
    input wire logic bank_select, // Current bank.
    input wire logic pair_transfer_size // Current move width.
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // An instruction counts only when it is not held off by a pending load.
    logic taken;
    logic run;
    assign taken = issue.valid && (issue.op != no_op) && !busy;
    assign run = taken && !fpu_disable;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // The load holds the unit off for exactly its settling time.
    sequence load_hold;
        busy [*4] ##1 !busy;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_trap_no_write: assert property (fpu_exception |-> !result.write_en)
        else $error("trap wrote the destination");
    a_illegal_pulse: assert property (taken && fpu_disable && !issue.delay_slot
        |=> illegal_instr && !slot_illegal_instr && !result.valid && !fpu_exception)
        else $error("disabled instruction not refused as illegal");
    a_slot_illegal: assert property (taken && fpu_disable && issue.delay_slot
        |=> slot_illegal_instr && !illegal_instr && !result.valid)
        else $error("disabled slot instruction not refused");
    a_bank_flip: assert property (run && issue.op == bank_toggle_op
        |=> bank_select != $past(bank_select) && $stable(pair_transfer_size))
        else $error("bank toggle did not flip in one cycle");
    a_size_flip: assert property (run && issue.op == size_toggle_op
        |=> pair_transfer_size != $past(pair_transfer_size) && $stable(bank_select))
        else $error("size toggle did not flip");
    a_load_busy: assert property (run && issue.op == control_load_op |=> load_hold)
        else $error("control load settling time wrong");
    a_pair_move: assert property (run && issue.op == float_move_op && pair_transfer_size
        |=> result.valid && result.pair && result.data == $past(issue.move_data))
        else $error("paired move lost a word");
    a_busy_ignore: assert property (busy && issue.valid |=> !result.valid && !fpu_exception)
        else $error("instruction taken during control load");
    a_gfx_answer: assert property (run && issue.op inside {inner_product_op, matrix_vector_op}
        |=> result.valid || fpu_exception)
        else $error("graphics op gave neither result nor trap");
endmodule : fpu_round_exception_chk

// [tb/fpu_round_exception_unit_tb_top.sv]
// Self-checking bench of the rounding and exception unit.
// Assumes the unit is the single AHB-Lite slave and answers with hreadyout.
`timescale 1ns/1ns
module fpu_round_exception_unit_tb_top
    import fpu_round_exception_pkg::*;
;
    localparam fpu_op_t TOPS [9] = '{inner_product_op, inner_product_op, matrix_vector_op, float_div_op,
        float_add_op, float_add_op, float_add_op, float_div_op, float_add_op};
    localparam logic [4:0] TEN [9] = '{5'h00, 5'h01, 5'h10, 5'h08, 5'h10, 5'h04, 5'h10, 5'h00, 5'h00};
    localparam logic [2:0] TIN [9] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h4, 3'h1, 3'h0, 3'h2, 3'h4};
    localparam logic [8:0] TTRAP = 9'b000111110;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, fpu_disable, fpu_exception, illegal_instr, slot_illegal_instr;
    logic busy, bank_select, pair_transfer_size;
    issue_t issue;
    result_t result;
    int err_count = 0, checked = 0, cycles = 0;
    int seed = 64730;

    // ------------------------------------------------------------------
    // Clock, instances and timeout
    // ------------------------------------------------------------------
    always #2 hclk = ~hclk;
    // A hung handshake must still end in the verdict.
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end
    fpu_round_exception_unit fpu_round_exception_unit_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .issue(issue), .fpu_disable(fpu_disable),
        .result(result), .fpu_exception(fpu_exception), .illegal_instr(illegal_instr),
        .slot_illegal_instr(slot_illegal_instr), .busy(busy), .bank_select(bank_select),
        .pair_transfer_size(pair_transfer_size));
    core_issue_model core_issue_model_i (.hclk(hclk), .busy(busy), .issue(issue), .fpu_disable(fpu_disable));

    // ------------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One single word transfer; each phase is held until hready is seen high.
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Issue one instruction, catch its answer cycle, then read the status word.
    task automatic run(input issue_t ins, input logic dis, output result_t r, output logic [2:0] ev,
        output logic [31:0] fs);
        core_issue_model_i.send(ins, dis, 1'b0);
        @(negedge hclk);
        r = result;
        ev = {fpu_exception, illegal_instr, slot_illegal_instr};
        ahb(32'h0, 1'b0, 32'h0, fs);
    endtask : run
    function automatic issue_t mk(input fpu_op_t op);
        issue_t i;
        i = '0;
        i.valid = 1'b1;
        i.op = op;
        i.exp = 12'h07f;
        i.sig = 53'h800000;
        return i;
    endfunction : mk
    // Ties go to the even neighbour; toward zero simply drops the round bit.
    function automatic logic [63:0] rounded(input issue_t i, input logic trunc);
        logic inc;
        inc = !trunc && i.round_bit && (i.sticky || i.sig[0]);
        return {32'h0, i.sign, i.exp[7:0], i.sig[22:0]} + 64'(inc);
    endfunction : rounded

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        issue_t ins;
        result_t r;
        logic [2:0] ev;
        logic [31:0] fs;
        logic fl;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(32'h0, 1'b0, 32'h0, fs);
        chk({31'h0, hresp, fs}, {32'h0, CTRL_RESET});
        ahb(32'h8, 1'b1, 32'hffffffff, fs);
        ahb(32'h8, 1'b0, 32'h0, fs);
        chk({32'h0, fs}, 64'h0);
        fl = 1'b0;
        for (int k = 0; k < 40; k++) begin
            if (k % 20 == 0) begin
                ahb(32'h0, 1'b1, {31'h0, k >= 20}, fs);
                fl = 1'b0;
            end
            ins = mk(fpu_op_t'(1 + k % 3));
            ins.sign = 1'($random(seed));
            ins.exp = 12'(1 + {$random(seed)} % 200);
            ins.sig = {30'h1, 23'($random(seed))};
            ins.round_bit = 1'($random(seed));
            ins.sticky = (k % 4 < 2) ? 1'b0 : 1'($random(seed));
            run(ins, 1'b0, r, ev, fs);
            fl = fl | ins.round_bit | ins.sticky;
            chk(r.data, rounded(ins, k >= 20));
            chk({58'h0, fs[17:12]}, {63'h0, ins.round_bit | ins.sticky});
            chk({59'h0, fs[6:2]}, {63'h0, fl});
        end
        for (int k = 0; k < 2; k++) begin
            ahb(32'h0, 1'b1, {31'h0, k[0]}, fs);
            ins = mk(float_mul_op);
            ins.sign = k[0];
            ins.exp = 12'h0ff;
            run(ins, 1'b0, r, ev, fs);
            chk(r.data, {32'h0, ins.sign, k[0] ? 31'h7f7fffff : 31'h7f800000});
            chk({62'h0, fs[14], fs[12]}, 64'h3);
        end
        for (int k = 0; k < 9; k++) begin
            ahb(32'h0, 1'b1, {20'h0, TEN[k], 7'h0}, fs);
            ins = mk(TOPS[k]);
            ins.sign = 1'b1;
            {ins.nan_input, ins.zero_divisor, ins.may_overflow} = TIN[k];
            run(ins, 1'b0, r, ev, fs);
            chk({62'h0, ev[2], r.write_en}, {62'h0, TTRAP[k], !TTRAP[k]});
            if (k < 3) begin
                chk({63'h0, fs[12] & fs[2]}, 64'h1);
            end
            if (k > 6) begin
                chk(r.data, k == 7 ? 64'hff800000 : QNAN_SP);
            end
        end
        for (int k = 0; k < 2; k++) begin
            ahb(32'h0, 1'b1, {13'h0, k[0], 18'h0}, fs);
            ins = mk(float_add_op);
            ins.denorm_input = 1'b1;
            ins.exp = 12'h0;
            ins.sig = 53'h1;
            ins.sticky = 1'b1;
            run(ins, 1'b0, r, ev, fs);
            chk({60'h0, ev[2], r.flush, fs[17], fs[13]}, {60'h0, !k[0], k[0], !k[0], 1'b1});
            chk(r.data, 64'h0);
        end
        ahb(32'h0, 1'b1, 32'h0, fs);
        run(mk(bank_toggle_op), 1'b0, r, ev, fs);
        run(mk(size_toggle_op), 1'b0, r, ev, fs);
        chk({60'h0, fs[21:20], bank_select, pair_transfer_size}, 64'hf);
        for (int k = 0; k < 2; k++) begin
            ins = mk(float_move_op);
            ins.move_data = {$random(seed), $random(seed)};
            run(ins, 1'b0, r, ev, fs);
            chk(r.data, k ? {32'h0, ins.move_data[31:0]} : ins.move_data);
            run(mk(size_toggle_op), 1'b0, r, ev, fs);
        end
        for (int k = 0; k < 2; k++) begin
            ins = mk(bank_toggle_op);
            ins.delay_slot = k[0];
            run(ins, 1'b1, r, ev, fs);
            chk({61'h0, ev[1:0], bank_select}, {61'h0, !k[0], k[0], 1'b1});
        end
        ins = mk(control_load_op);
        ins.move_data = 64'hffffffff;
        core_issue_model_i.send(ins, 1'b0, 1'b0);
        core_issue_model_i.send(mk(float_add_op), 1'b0, 1'b1);
        repeat (6) @(posedge hclk);
        ahb(32'h0, 1'b0, 32'h0, fs);
        chk({32'h0, fs}, {32'h0, CTRL_WMASK});
        finish_test();
    end
endmodule : fpu_round_exception_unit_tb_top

bind fpu_round_exception_unit fpu_round_exception_chk fpu_round_exception_chk_i (.hclk, .hresetn, .issue,
    .fpu_disable, .result, .fpu_exception, .illegal_instr, .slot_illegal_instr, .busy, .bank_select,
    .pair_transfer_size);
